// File: srb_bitop.sv
// Purpose: combinational single-bit operations on a byte
// Assumes: bit number already selected
// Notes:   carry-combining ops use the immediate only
`timescale 1ns/10ps
`default_nettype none
module srb_bitop (
    // request
    input  wire logic [4:0] op,
    input  wire logic [7:0] din,
    input  wire logic [2:0] bitno,
    input  wire logic       cin,
    input  wire logic       zin,
    // result
    output logic      [7:0] dout,
    output logic            cout,
    output logic            zout
);
    logic sel;

    always_comb begin
        dout = din;
        cout = cin;
        zout = zin;
        sel  = din[bitno];
        case (op)
            5'h08: dout[bitno] = 1'b1;
            5'h09: dout[bitno] = 1'b0;
            5'h0A: dout[bitno] = ~sel;
            5'h0B: zout = ~sel;
            5'h0C: cout = cin & sel;
            5'h0D: cout = cin & ~sel;
            5'h0E: cout = cin | sel;
            5'h0F: cout = cin | ~sel;
            default: dout = din;
        endcase
    end
endmodule : srb_bitop
`default_nettype wire

// File: srb_pkg.sv
// Purpose: shared types and constants for the shift/rotate/bit unit
// Assumes: 16-bit core, operands up to 32 bits wide
// Notes:   opcodes are local encodings
package srb_pkg;

    localparam int DATA_W   = 32;
    localparam int BITNO_W  = 3;
    localparam int BYTE_W   = 8;
    localparam int LAT_CYC  = 1;
    localparam int MEM_RD_CYC = 1;

    typedef enum logic [1:0] {
        SRB_SZ_BYTE = 2'h0,
        SRB_SZ_WORD = 2'h1,
        SRB_SZ_LONG = 2'h2
    } srb_size_t;

    typedef enum logic [4:0] {
        SRB_OP_ARITH_SHIFT_LEFT   = 5'h00,
        SRB_OP_ARITH_SHIFT_RIGHT  = 5'h01,
        SRB_OP_LOGIC_SHIFT_LEFT   = 5'h02,
        SRB_OP_LOGIC_SHIFT_RIGHT  = 5'h03,
        SRB_OP_ROTATE_LEFT        = 5'h04,
        SRB_OP_ROTATE_RIGHT       = 5'h05,
        SRB_OP_CARRY_ROTATE_LEFT  = 5'h06,
        SRB_OP_CARRY_ROTATE_RIGHT = 5'h07,
        SRB_OP_BIT_FORCE_ONE      = 5'h08,
        SRB_OP_BIT_FORCE_ZERO     = 5'h09,
        SRB_OP_BIT_INVERT         = 5'h0A,
        SRB_OP_BIT_TEST_ZERO_FLAG = 5'h0B,
        SRB_OP_BIT_AND_CARRY      = 5'h0C,
        SRB_OP_INV_BIT_AND_CARRY  = 5'h0D,
        SRB_OP_BIT_OR_CARRY       = 5'h0E,
        SRB_OP_INV_BIT_OR_CARRY   = 5'h0F
    } srb_op_t;

    // one request from the decoder
    typedef struct packed {
        srb_op_t           op;
        srb_size_t         size;
        logic              two;        // shift/rotate by 2
        logic              bit_src_reg; // bit number from register
        logic [2:0]        bit_imm;
        logic [2:0]        bit_reg;
        logic              mem;        // byte operand lives in memory
        logic [DATA_W-1:0] operand;
        logic              carry;
        logic              zero;
    } srb_req_t;

    // result handed to writeback
    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic              wr_reg;
        logic              wr_mem;
        logic              carry;
        logic              zero;
        logic              illegal;
    } srb_rsp_t;

endpackage : srb_pkg

// File: srb_shifter.sv
// Purpose: combinational shift and rotate by one or two places
// Assumes: operand right-aligned in its size
// Notes:   carry is last bit shifted out
`timescale 1ns/10ps
`default_nettype none
module srb_shifter #(
    parameter int W = srb_pkg::DATA_W
) (
    // request
    input  wire logic              [4:0]   op,
    input  wire srb_pkg::srb_size_t        size,
    input  wire logic                      two,
    input  wire logic              [W-1:0] din,
    input  wire logic                      cin,
    // result
    output logic                   [W-1:0] dout,
    output logic                           cout
);
    if (W != 32) begin : g_w_chk
        $error("srb_shifter: width must be 32");
    end

    logic [W-1:0] v;
    logic         c;
    logic         msb;
    int           n;
    int           top;

    always_comb begin
        v    = din;
        c    = cin;
        msb  = 1'b0;
        top  = (size == srb_pkg::SRB_SZ_BYTE) ? 7 : (size == srb_pkg::SRB_SZ_WORD) ? 15 : 31;
        for (n = 0; n < 2; n++) begin
            if (n == 0 || two) begin
                msb = v[top];
                case (op)
                    5'h00, 5'h02: begin
                        c = v[top];
                        v = {v[W-2:0], 1'b0};
                    end
                    5'h01: begin
                        c = v[0];
                        v = v >> 1;
                        v[top] = msb;
                    end
                    5'h03: begin
                        c = v[0];
                        v = v >> 1;
                        v[top] = 1'b0;
                    end
                    5'h04: begin
                        c = v[top];
                        v = {v[W-2:0], msb};
                    end
                    5'h05: begin
                        c = v[0];
                        v = v >> 1;
                        v[top] = c;
                    end
                    5'h06: begin
                        v = {v[W-2:0], c};
                        c = msb;
                    end
                    5'h07: begin
                        msb = v[0];
                        v = v >> 1;
                        v[top] = c;
                        c = msb;
                    end
                    default: begin
                        v = v;
                    end
                endcase
            end
        end
        dout = v;
        if (size == srb_pkg::SRB_SZ_BYTE) dout[W-1:8] = din[W-1:8];
        else if (size == srb_pkg::SRB_SZ_WORD) dout[W-1:16] = din[W-1:16];
        cout = c;
    end
endmodule : srb_shifter
`default_nettype wire

// File: srb_unit.sv
// Purpose: shift, rotate and single-bit datapath slice of a 16-bit core
// Assumes: decoder supplies operand and flags; for memory the byte comes back on mem_rd_data after a mem_rd request
// Notes:   one-cycle registered result for register operands; memory bit writes are read-modify-write
//
// Behaviour
// - arithmetic shifts move a byte, word or long register by one or two places and write it back
// - logical shifts move by one or two places, fill with zero and write it back
// - plain rotates move by one or two places with bits wrapping end to end
// - carry rotates move by one or two places with carry as an extra bit in the loop
// - bit set forces the chosen bit of a register or memory byte to one
// - bit clear forces the chosen bit to zero, others unchanged
// - bit invert complements the chosen bit and writes the byte back
// - bit test loads Z with the inverse of the chosen bit, operand unchanged
// - set, clear, invert and test take the bit number from an immediate or a register's low three bits
// - bit and-carry sets carry to carry AND the chosen bit
// - inverted bit and-carry sets carry to carry AND NOT the chosen bit
// - bit or-carry sets carry to carry OR the chosen bit
// - inverted bit or-carry sets carry to carry OR NOT the chosen bit
// - carry-combining ops take the bit number only from the immediate
`timescale 1ns/10ps
`default_nettype none
module srb_unit (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                ce,
    // request
    input  wire logic                req_valid,
    input  wire srb_pkg::srb_req_t   req,
    output logic                     req_ready,
    // memory byte path
    output logic                     mem_rd,
    input  wire logic                mem_rd_valid,
    input  wire logic [7:0]          mem_rd_data,
    // result
    output logic                     rsp_valid,
    output srb_pkg::srb_rsp_t        rsp
);
    typedef enum logic [2:0] {
        SRB_IDLE = 3'b001,
        SRB_READ = 3'b010,
        SRB_WAIT = 3'b100
    } srb_state_t;

    srb_state_t        state_ff, nxt_state;
    srb_pkg::srb_req_t hold_ff, nxt_hold;
    srb_pkg::srb_rsp_t rsp_ff, nxt_rsp;
    logic              rsp_valid_ff, nxt_rsp_valid;
    logic              mem_rd_ff, nxt_mem_rd;

    srb_pkg::srb_req_t cur;
    logic [7:0]        bit_in;
    logic [2:0]        bitno;
    logic              is_bit;
    logic              is_comb;
    logic              is_mod;
    logic [31:0]       sh_out;
    logic              sh_c;
    logic [7:0]        b_out;
    logic              b_c;
    logic              b_z;
    logic              go;

    assign req_ready = state_ff[0];
    assign rsp_valid = rsp_valid_ff;
    assign rsp       = rsp_ff;
    assign mem_rd    = mem_rd_ff;

    always_comb begin
        cur     = (state_ff == SRB_IDLE) ? req : hold_ff;
        is_bit  = cur.op[3];
        is_comb = cur.op[3] & cur.op[2];
        is_mod  = is_bit & ~cur.op[2] & (cur.op[1:0] != 2'h3);
        bitno   = (cur.bit_src_reg && !is_comb) ? cur.bit_reg : cur.bit_imm;
        bit_in  = (state_ff != SRB_IDLE) ? mem_rd_data : cur.operand[7:0];
    end

    srb_shifter #(.W(srb_pkg::DATA_W)) u_shift (
        .op   (cur.op),
        .size (cur.size),
        .two  (cur.two),
        .din  (cur.operand),
        .cin  (cur.carry),
        .dout (sh_out),
        .cout (sh_c)
    );

    srb_bitop u_bit (
        .op    (cur.op),
        .din   (bit_in),
        .bitno (bitno),
        .cin   (cur.carry),
        .zin   (cur.zero),
        .dout  (b_out),
        .cout  (b_c),
        .zout  (b_z)
    );

    always_comb begin
        nxt_state     = state_ff;
        nxt_hold      = hold_ff;
        nxt_rsp       = rsp_ff;
        nxt_rsp_valid = 1'b0;
        nxt_mem_rd    = 1'b0;
        go            = 1'b0;
        case (state_ff)
            SRB_IDLE: begin
                if (req_valid) begin
                    nxt_hold = req;
                    if (req.op[3] && req.mem) begin
                        nxt_state  = SRB_READ;
                        nxt_mem_rd = 1'b1;
                    end else begin
                        go = 1'b1;
                    end
                end
            end
            SRB_READ: begin
                nxt_state = SRB_WAIT;
            end
            SRB_WAIT: begin
                if (mem_rd_valid) begin
                    go        = 1'b1;
                    nxt_state = SRB_IDLE;
                end
            end
            default: nxt_state = SRB_IDLE;
        endcase
        if (go) begin
            nxt_rsp_valid   = 1'b1;
            nxt_rsp.illegal = 1'b0;
            if (is_bit) begin
                nxt_rsp.data   = {24'h000000, b_out};
                nxt_rsp.carry  = b_c;
                nxt_rsp.zero   = b_z;
                nxt_rsp.wr_reg = is_mod & ~cur.mem;
                nxt_rsp.wr_mem = is_mod & cur.mem;
            end else begin
                nxt_rsp.data    = sh_out;
                nxt_rsp.carry   = sh_c;
                nxt_rsp.zero    = cur.zero;
                nxt_rsp.wr_reg  = 1'b1;
                nxt_rsp.wr_mem  = 1'b0;
                nxt_rsp.illegal = cur.size == 2'h3;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff     <= SRB_IDLE;
            hold_ff      <= '0;
            rsp_ff       <= '0;
            rsp_valid_ff <= 1'b0;
            mem_rd_ff    <= 1'b0;
        end else if (ce) begin
            state_ff     <= nxt_state;
            hold_ff      <= nxt_hold;
            rsp_ff       <= nxt_rsp;
            rsp_valid_ff <= nxt_rsp_valid;
            mem_rd_ff    <= nxt_mem_rd;
        end
    end

    // checks
    property p_set_one;
        @(posedge clk) disable iff (rst)
        (ce && req_ready && req_valid && !req.mem && req.op == srb_pkg::SRB_OP_BIT_FORCE_ONE
         && !req.bit_src_reg)
        |=> rsp_valid && rsp.data[$past(req.bit_imm)] == 1'b1;
    endproperty
    bit_set_one_a: assert property (p_set_one) else $error("bit set failed");

    bit_clear_zero_a: assert property (@(posedge clk) disable iff (rst)
        (ce && req_ready && req_valid && !req.mem && req.op == srb_pkg::SRB_OP_BIT_FORCE_ZERO
         && !req.bit_src_reg) |=> rsp.data[$past(req.bit_imm)] == 1'b0)
        else $error("bit clear failed");

    bit_test_z_a: assert property (@(posedge clk) disable iff (rst)
        (ce && req_ready && req_valid && !req.mem && req.op == srb_pkg::SRB_OP_BIT_TEST_ZERO_FLAG
         && !req.bit_src_reg) |=> rsp.zero == ~$past(req.operand[req.bit_imm]) && !rsp.wr_reg)
        else $error("bit test flag wrong");

    and_carry_a: assert property (@(posedge clk) disable iff (rst)
        (ce && req_ready && req_valid && !req.mem && req.op == srb_pkg::SRB_OP_BIT_AND_CARRY)
        |=> rsp.carry == ($past(req.carry) & $past(req.operand[req.bit_imm])))
        else $error("and carry wrong");

    or_inv_carry_a: assert property (@(posedge clk) disable iff (rst)
        (ce && req_ready && req_valid && !req.mem && req.op == srb_pkg::SRB_OP_INV_BIT_OR_CARRY)
        |=> rsp.carry == ($past(req.carry) | ~$past(req.operand[req.bit_imm])))
        else $error("inverted or carry wrong");

    shl_byte_a: assert property (@(posedge clk) disable iff (rst)
        (ce && req_ready && req_valid && req.op == srb_pkg::SRB_OP_LOGIC_SHIFT_LEFT
         && req.size == srb_pkg::SRB_SZ_BYTE && !req.two)
        |=> rsp.data[7:0] == {$past(req.operand[6:0]), 1'b0} && rsp.carry == $past(req.operand[7]))
        else $error("logical shift wrong");

    sar_sign_a: assert property (@(posedge clk) disable iff (rst)
        (ce && req_ready && req_valid && req.op == srb_pkg::SRB_OP_ARITH_SHIFT_RIGHT
         && req.size == srb_pkg::SRB_SZ_WORD) |=> rsp.data[15] == $past(req.operand[15]))
        else $error("sign not kept");

    mem_rmw_a: assert property (@(posedge clk) disable iff (rst)
        (ce && req_ready && req_valid && req.mem && req.op == srb_pkg::SRB_OP_BIT_INVERT)
        |=> mem_rd ##1 !rsp_valid)
        else $error("memory read missing");

    reg_bitno_a: assert property (@(posedge clk) disable iff (rst)
        (ce && req_ready && req_valid && !req.mem && req.op == srb_pkg::SRB_OP_BIT_FORCE_ONE
         && req.bit_src_reg) |=> rsp.data[$past(req.bit_reg)] == 1'b1)
        else $error("register bit number ignored");

    and_inv_carry_a: assert property (@(posedge clk) disable iff (rst)
        (ce && req_ready && req_valid && !req.mem && req.op == srb_pkg::SRB_OP_INV_BIT_AND_CARRY)
        |=> rsp.carry == ($past(req.carry) & ~$past(req.operand[req.bit_imm])))
        else $error("inverted and carry wrong");

    or_carry_a: assert property (@(posedge clk) disable iff (rst)
        (ce && req_ready && req_valid && !req.mem && req.op == srb_pkg::SRB_OP_BIT_OR_CARRY)
        |=> rsp.carry == ($past(req.carry) | $past(req.operand[req.bit_imm])))
        else $error("or carry wrong");

    cov_rmw_c:  cover property (@(posedge clk) rsp_valid && rsp.wr_mem);
    cov_rot2_c: cover property (@(posedge clk) ce && req_valid && req_ready && req.two
                                && req.op == srb_pkg::SRB_OP_CARRY_ROTATE_RIGHT);
    cov_reg_c:  cover property (@(posedge clk) ce && req_valid && req_ready && req.bit_src_reg);

endmodule : srb_unit
`default_nettype wire

// File: tb_srb_unit.sv
// Purpose: self-checking bench for the shift, rotate and bit unit
// Assumes: one-cycle register results, memory byte supplied on request
// Notes:   expectations computed here from operand, size and carry
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
    $display("[ERR] %0t got %h expected %h", $time, (a), (b)); end end
module tb_srb_unit;
    // design signals
    logic              clk;
    logic              rst;
    logic              ce;
    logic              req_valid;
    srb_pkg::srb_req_t rq;
    logic              req_ready;
    logic              mem_rd;
    logic              mem_rd_valid;
    logic [7:0]        mem_rd_data;
    logic              rsp_valid;
    srb_pkg::srb_rsp_t rsp;
    int                miscompares;
    int                checks;
    int                rds;

    srb_unit dut_u (.clk(clk), .rst(rst), .ce(ce), .req_valid(req_valid), .req(rq),
        .req_ready(req_ready), .mem_rd(mem_rd), .mem_rd_valid(mem_rd_valid),
        .mem_rd_data(mem_rd_data), .rsp_valid(rsp_valid), .rsp(rsp));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic end_of_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    // issue rq, serve one memory read if asked, wait for the result
    task automatic run(input logic [7:0] mb);
        int n;
        @(negedge clk);
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        n = 0;
        rds = 0;
        while (rsp_valid !== 1'b1 && n < 20) begin
            if (mem_rd === 1'b1) begin
                rds++;
                mem_rd_valid = 1'b1;
                mem_rd_data = mb;
            end
            @(negedge clk);
            n++;
        end
        mem_rd_valid = 1'b0;
        mem_rd_data = ~mb;
        if (rsp_valid !== 1'b1) begin
            miscompares++;
            $display("[ERR] %0t no response", $time);
            end_of_test();
        end
    endtask : run

    // reference shift: returns {carry, data}
    function automatic logic [32:0] exp_sh(int op, int w, logic two, logic [31:0] d,
                                           logic c);
        logic [31:0] v;
        logic [31:0] m;
        logic        ins;
        m = (w == 32) ? 32'hFFFF_FFFF : ((32'h1 << w) - 32'h1);
        v = d & m;
        for (int i = 0; i <= int'(two); i++) begin
            if (op % 2 == 0) begin
                ins = (op == 4) ? v[w-1] : (op == 6) ? c : 1'b0;
                c = v[w-1];
                v = ((v << 1) | {31'h0, ins}) & m;
            end else begin
                ins = (op == 1) ? v[w-1] : (op == 5) ? v[0] : (op == 7) ? c : 1'b0;
                c = v[0];
                v = (v >> 1) | ({31'h0, ins} << (w - 1));
            end
        end
        return {c, (d & ~m) | v};
    endfunction : exp_sh

    task automatic t_shift;
        logic [32:0] e;
        for (int op = 0; op < 8; op++) begin
            for (int sz = 0; sz < 3; sz++) begin
                for (int t = 0; t < 2; t++) begin
                    rq = '0;
                    rq.op = srb_pkg::srb_op_t'(5'(op));
                    rq.size = srb_pkg::srb_size_t'(2'(sz));
                    rq.two = t[0];
                    rq.operand = 32'h81C3_A4C1;
                    rq.carry = ~t[0];
                    e = exp_sh(op, 8 << sz, t[0], rq.operand, rq.carry);
                    run(8'h00);
                    `CHK(rsp.data, e[31:0])
                    `CHK(rsp.carry, e[32])
                    `CHK({rsp.wr_reg, rsp.illegal}, 2'h2)
                end
            end
        end
        $display("test shift done");
    endtask : t_shift

    task automatic t_bit_reg;
        logic [7:0] m;
        logic [7:0] e;
        for (int op = 8; op < 12; op++) begin
            for (int n = 0; n < 8; n++) begin
                rq = '0;
                rq.op = srb_pkg::srb_op_t'(5'(op));
                rq.bit_src_reg = n[0];
                rq.bit_imm = n[0] ? ~3'(n) : 3'(n);
                rq.bit_reg = n[0] ? 3'(n) : ~3'(n);
                rq.operand = 32'h0000_005A;
                m = 8'h01 << n;
                e = (op == 8) ? 8'h5A | m : (op == 9) ? 8'h5A & ~m : (op == 10) ? 8'h5A ^ m : 8'h5A;
                run(8'h00);
                `CHK(rsp.data[7:0], e)
                `CHK(rsp.wr_reg, op != 11)
                if (op == 11) `CHK(rsp.zero, ~e[n])
            end
        end
        $display("test bit register done");
    endtask : t_bit_reg

    task automatic t_bit_mem;
        logic [7:0] e;
        for (int op = 8; op < 12; op++) begin
            rq = '0;
            rq.op = srb_pkg::srb_op_t'(5'(op));
            rq.bit_imm = 3'h5;
            rq.mem = 1'b1;
            rq.operand = 32'h0000_00FF;
            e = (op == 8) ? 8'hB6 : (op == 9) ? 8'h96 : (op == 10) ? 8'hB6 : 8'h96;
            run(8'h96);
            `CHK(rds, 1)
            `CHK(rsp.data[7:0], e)
            `CHK({rsp.wr_mem, rsp.wr_reg}, {op != 11, 1'b0})
            if (op == 11) `CHK(rsp.zero, 1'b1)
        end
        $display("test bit memory done");
    endtask : t_bit_mem

    task automatic t_carry;
        logic b;
        logic e;
        for (int op = 12; op < 16; op++) begin
            for (int k = 0; k < 4; k++) begin
                rq = '0;
                rq.op = srb_pkg::srb_op_t'(5'(op));
                rq.carry = k[0];
                rq.bit_imm = k[1] ? 3'h2 : 3'h3;
                rq.bit_src_reg = 1'b1;
                rq.bit_reg = ~rq.bit_imm;
                rq.operand = 32'h0000_0084;
                b = k[1];
                e = (op == 12) ? k[0] & b : (op == 13) ? k[0] & ~b : (op == 14) ? k[0] | b : k[0] | ~b;
                run(8'h00);
                `CHK(rsp.carry, e)
                `CHK({rsp.wr_reg, rsp.wr_mem}, 2'h0)
            end
        end
        $display("test carry bit done");
    endtask : t_carry

    task automatic t_illegal;
        rq = '0;
        rq.op = srb_pkg::SRB_OP_LOGIC_SHIFT_LEFT;
        rq.size = srb_pkg::srb_size_t'(2'h3);
        run(8'h00);
        `CHK(rsp.illegal, 1'b1)
        $display("test illegal size done");
    endtask : t_illegal

    // a request offered while ce is low must not be taken
    task automatic t_freeze;
        logic [31:0] d;
        d = rsp.data;
        rq = '0;
        rq.op = srb_pkg::SRB_OP_ROTATE_LEFT;
        rq.operand = 32'h0000_0081;
        @(negedge clk);
        ce = 1'b0;
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        `CHK({rsp_valid, rsp.data}, {1'b0, d})
        ce = 1'b1;
        run(8'h00);
        `CHK({rsp.carry, rsp.data[7:0]}, 9'h103)
        $display("test clock enable done");
    endtask : t_freeze

    initial begin
        miscompares = 0;
        checks = 0;
        rst = 1'b1;
        ce = 1'b1;
        req_valid = 1'b0;
        rq = '0;
        mem_rd_valid = 1'b0;
        mem_rd_data = 8'hA5;
        repeat (10) @(negedge clk);
        `CHK({req_ready, rsp_valid, mem_rd}, 3'h4)
        rst = 1'b0;
        t_shift();
        t_bit_reg();
        t_bit_mem();
        t_carry();
        t_illegal();
        t_freeze();
        end_of_test();
    end
endmodule : tb_srb_unit
`default_nettype wire
